// ==== design/npec_checker.sv ====
// NAND page code checker: watches the flash bus, builds and checks the page code.
// Functional notes
// - Page lengths 528, 1056, 2112, 4224 words selectable.
// - Handles 8-bit and 16-bit page words.
// - Read 00h or program 80h starts computation.
// - Code ready when main-area word count ends on program; on read, after the stored code is checked.
// - Results frozen until next read or program command, or until a software reset.
// - Zero syndrome reports no error, flags clear.
// - Single data error: flag, word offset, bit.
// - Error inside stored code sets its flag.
// - Uncorrectable errors set the multiple-error flag.
// - Command clears all results; so does software reset, except in the cycle of the last main-area word or of the code check.
// - 32-bit correcting code per main area.
// - 26 line bits and 6 column bits.
// - Word parity folds into line terms by index.
`timescale 1ns/10ps
module npec_checker (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  ce,
	input  wire logic                  sw_reset,
	input  wire logic [1:0]            page_length_select,
	input  wire logic                  word16,
	input  wire npec_pkg::npec_bus_s   bus,
	output logic [15:0]                parity_result_register,
	output logic [15:0]                inverse_parity_register,
	output npec_pkg::npec_status_s     check_status_register,
	output logic [11:0]                faulty_word_offset,
	output logic [3:0]                 faulty_bit_position,
	output logic                       code_ready
);
	import npec_pkg::*;

	npec_state_e   state_q;
	logic [12:0]   count_q;
	logic [12:0]   main_words;
	logic          is_read_q;
	logic          addr_seen_q;
	npec_code_s    acc_q;
	npec_code_s    term;
	logic [15:0]   parity_q;
	logic [15:0]   inverse_q;
	npec_status_s  status_q;
	logic          ready_q;
	logic [31:0]   stored_q;
	logic [31:0]   stored_d;
	logic [2:0]    piece_q;
	logic [2:0]    pieces;

	logic          cmd_cyc;
	logic          start_cmd;
	logic          data_cyc;
	logic          last_main;
	logic          last_piece;
	logic          check_now;
	logic [15:0]   synd_p;
	logic [15:0]   synd_n;
	logic [15:0]   location;
	logic          syn_zero;
	logic          syn_single;
	logic          syn_code;

	function automatic logic [4:0] ones16(input logic [15:0] v);
		logic [4:0] n;
		n = 5'h00;
		for (int b = 0; b < 16; b++) begin
			n = n + {4'h0, v[b]};
		end
		return n;
	endfunction : ones16

	// Command latch and data cycles are told apart by the latch enables.
	assign cmd_cyc   = bus.cyc & bus.wr & bus.cle;
	assign start_cmd = cmd_cyc & ((bus.data[7:0] == NPEC_CMD_READ)
		| (bus.data[7:0] == NPEC_CMD_PROGRAM));
	assign data_cyc  = bus.cyc & ~bus.cle & ~bus.ale;

	assign main_words = NPEC_MAIN_BASE_WORDS << page_length_select;
	assign last_main  = (state_q == NPEC_DATA) & data_cyc
		& (count_q == main_words - 13'h0001);
	assign pieces     = word16 ? NPEC_PIECES_WORD : NPEC_PIECES_BYTE;
	assign last_piece = (state_q == NPEC_CODE) & data_cyc
		& (piece_q == pieces - 3'h1);
	assign check_now  = last_piece & ce & ~start_cmd;

	npec_parity u_parity (
		.data   (bus.data),
		.word16 (word16),
		.index  (count_q[11:0]),
		.term   (term)
	);

	// State sequence: command, address cycles, main area, stored code, locked.
	always_ff @(posedge mclk) begin
		if (rst || (ce && sw_reset)) begin
			state_q <= NPEC_IDLE;
		end else if (ce) begin
			if (start_cmd) begin
				state_q <= NPEC_ADDR;
			end else begin
				case (state_q)
					NPEC_ADDR: begin
						if (data_cyc && addr_seen_q) begin
							state_q <= (main_words == 13'h0001) ? NPEC_DONE : NPEC_DATA;
						end
					end
					NPEC_DATA: begin
						if (last_main) begin
							state_q <= is_read_q ? NPEC_CODE : NPEC_DONE;
						end
					end
					NPEC_CODE: begin
						if (last_piece) begin
							state_q <= NPEC_DONE;
						end
					end
					default: begin
						state_q <= state_q;
					end
				endcase
			end
		end
	end

	// Direction and address phase tracking.
	always_ff @(posedge mclk) begin
		if (rst) begin
			is_read_q   <= 1'b0;
			addr_seen_q <= 1'b0;
		end else if (ce) begin
			if (start_cmd) begin
				is_read_q   <= (bus.data[7:0] == NPEC_CMD_READ);
				addr_seen_q <= 1'b0;
			end else if (state_q == NPEC_ADDR && bus.cyc && bus.ale) begin
				addr_seen_q <= 1'b1;
			end
		end
	end

	// Word counter; the first data cycle after the address is word zero.
	always_ff @(posedge mclk) begin
		if (rst) begin
			count_q <= NPEC_COUNT_RST;
		end else if (ce) begin
			if (start_cmd) begin
				count_q <= NPEC_COUNT_RST;
			end else if (state_q == NPEC_ADDR && data_cyc && addr_seen_q) begin
				count_q <= 13'h0001;
			end else if (state_q == NPEC_DATA && data_cyc) begin
				count_q <= count_q + 13'h0001;
			end
		end
	end

	// Running code over the main area; the first word is folded on entry.
	always_ff @(posedge mclk) begin
		if (rst) begin
			acc_q <= '0;
		end else if (ce) begin
			if (start_cmd) begin
				acc_q <= '0;
			end else if (state_q == NPEC_ADDR && data_cyc && addr_seen_q) begin
				acc_q <= term;
			end else if (state_q == NPEC_DATA && data_cyc) begin
				acc_q <= acc_q ^ term;
			end
		end
	end

	// Stored code pieces, low piece of the parity half first.
	always_comb begin
		stored_d = stored_q;
		if (word16) begin
			stored_d[piece_q[0]*16 +: 16] = bus.data;
		end else begin
			stored_d[piece_q[1:0]*8 +: 8] = bus.data[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			stored_q <= 32'h00000000;
			piece_q  <= 3'h0;
		end else if (ce) begin
			if (start_cmd) begin
				stored_q <= 32'h00000000;
				piece_q  <= 3'h0;
			end else if (state_q == NPEC_CODE && data_cyc) begin
				stored_q <= stored_d;
				piece_q  <= piece_q + 3'h1;
			end
		end
	end

	// Syndrome: parity half in the low word, inverse half in the high word.
	assign synd_p     = parity_q ^ stored_d[15:0];
	assign synd_n     = inverse_q ^ stored_d[31:16];
	assign syn_zero   = (synd_p == 16'h0000) && (synd_n == 16'h0000);
	assign syn_single = ((synd_p ^ synd_n) == 16'hffff);
	assign syn_code   = ((ones16(synd_p) + ones16(synd_n)) == 5'h01);
	assign location   = word16 ? synd_p : {synd_p[14:3], 1'b0, synd_p[2:0]};

	// Result registers: cleared by command, and by software reset except in a last_main or check_now cycle; then locked.
	always_ff @(posedge mclk) begin
		if (rst) begin
			parity_q  <= NPEC_PARITY_RST;
			inverse_q <= NPEC_PARITY_RST;
			status_q  <= '0;
			ready_q   <= 1'b0;
		end else if (ce) begin
			if (start_cmd || sw_reset) begin
				parity_q  <= NPEC_PARITY_RST;
				inverse_q <= NPEC_PARITY_RST;
				status_q  <= '0;
				ready_q   <= 1'b0;
			end
			if (last_main && !start_cmd) begin
				parity_q  <= acc_q[31:16] ^ term[31:16];
				inverse_q <= acc_q[15:0] ^ term[15:0];
				ready_q   <= ~is_read_q;
			end
			if (check_now) begin
				ready_q <= 1'b1;
				if (syn_zero) begin
					status_q <= '0;
				end else if (syn_single) begin
					status_q.correctable_error_flag <= 1'b1;
					parity_q <= location;
				end else if (syn_code) begin
					status_q.stored_code_error_flag <= 1'b1;
				end else begin
					status_q.multiple_error_flag <= 1'b1;
				end
			end
		end
	end

	assign parity_result_register  = parity_q;
	assign inverse_parity_register = inverse_q;
	assign check_status_register   = status_q;
	assign faulty_word_offset      = parity_q[15:4];
	assign faulty_bit_position     = parity_q[3:0];
	assign code_ready              = ready_q;

	// Checks.
	cmd_clear_a: assert property (@(posedge mclk) disable iff (rst)
		(ce && start_cmd) |=> (status_q == '0) && (parity_q == 16'h0000) && !ready_q)
		else $error("results not cleared after a command");

	start_addr_a: assert property (@(posedge mclk) disable iff (rst)
		(ce && start_cmd && !sw_reset) |=> (state_q == NPEC_ADDR) && (count_q == 13'h0000))
		else $error("start command did not open the address phase");

	count_step_a: assert property (@(posedge mclk) disable iff (rst)
		(ce && state_q == NPEC_DATA && data_cyc && !start_cmd && !sw_reset && !last_main)
		|=> (count_q == $past(count_q) + 13'h0001))
		else $error("word counter did not advance by one");

	main_end_a: assert property (@(posedge mclk) disable iff (rst)
		(ce && last_main && !start_cmd && !sw_reset && !is_read_q)
		|=> ready_q && (state_q == NPEC_DONE))
		else $error("code not ready at end of main area");

	lock_hold_a: assert property (@(posedge mclk) disable iff (rst)
		(state_q == NPEC_DONE && !start_cmd && !sw_reset)
		|=> $stable(parity_q) && $stable(inverse_q) && $stable(status_q))
		else $error("locked results changed");

	no_error_a: assert property (@(posedge mclk) disable iff (rst)
		(check_now && !sw_reset && syn_zero) |=> (status_q == '0) ##1 (status_q == '0))
		else $error("flag set on a clean page");

	one_fix_a: assert property (@(posedge mclk) disable iff (rst)
		(check_now && !syn_zero && syn_single)
		|=> (status_q == 3'b001) && (parity_q == $past(location)))
		else $error("correctable error not reported with its location");

	code_err_a: assert property (@(posedge mclk) disable iff (rst)
		(check_now && !syn_zero && !syn_single && syn_code)
		|=> status_q.stored_code_error_flag && !status_q.correctable_error_flag)
		else $error("stored code error not flagged");

	multi_err_a: assert property (@(posedge mclk) disable iff (rst)
		(check_now && !syn_zero && !syn_single && !syn_code)
		|=> status_q.multiple_error_flag && !status_q.correctable_error_flag)
		else $error("multiple error not flagged");

	page_len_a: assert property (@(posedge mclk) disable iff (rst)
		last_main |-> (count_q == (page_length_select == NPEC_PSEL_4224 ? 13'h0fff :
			page_length_select == NPEC_PSEL_2112 ? 13'h07ff :
			page_length_select == NPEC_PSEL_1056 ? 13'h03ff : 13'h01ff)))
		else $error("main area length does not match page selection");

endmodule : npec_checker

// ==== design/npec_pkg.sv ====
// Shared constants and types of the NAND page code checker.
package npec_pkg;

	// Flash commands that open a covered access.
	localparam logic [7:0] NPEC_CMD_READ    = 8'h00;
	localparam logic [7:0] NPEC_CMD_PROGRAM = 8'h80;

	// Page length selection codes: 528, 1056, 2112 and 4224 words.
	localparam logic [1:0] NPEC_PSEL_528  = 2'h0;
	localparam logic [1:0] NPEC_PSEL_1056 = 2'h1;
	localparam logic [1:0] NPEC_PSEL_2112 = 2'h2;
	localparam logic [1:0] NPEC_PSEL_4224 = 2'h3;

	// Main area of the smallest page; each larger selection doubles it.
	localparam logic [12:0] NPEC_MAIN_BASE_WORDS = 13'h0200;

	// Code field layout: 13 line bits and 3 column bits per parity half.
	localparam int NPEC_LINE_BITS = 13;
	localparam int NPEC_COL_BITS  = 3;
	localparam int NPEC_HALF_BITS = NPEC_LINE_BITS + NPEC_COL_BITS;

	// Column masks: bit positions inside a byte whose column index bit is set.
	localparam logic [2:0][7:0] NPEC_COL_MASK = {8'hf0, 8'hcc, 8'haa};

	// Stored code pieces read back after the main area.
	localparam logic [2:0] NPEC_PIECES_BYTE = 3'h4;
	localparam logic [2:0] NPEC_PIECES_WORD = 3'h2;

	// Reset values.
	localparam logic [15:0] NPEC_PARITY_RST = 16'h0000;
	localparam logic [12:0] NPEC_COUNT_RST  = 13'h0000;

	// Observed static memory bus cycle, one strobe per access.
	typedef struct packed {
		logic        cyc;
		logic        wr;
		logic        cle;
		logic        ale;
		logic [15:0] data;
	} npec_bus_s;

	// One code: parity half and inverse-parity half.
	typedef struct packed {
		logic [12:0] p_line;
		logic [2:0]  p_col;
		logic [12:0] n_line;
		logic [2:0]  n_col;
	} npec_code_s;

	typedef struct packed {
		logic multiple_error_flag;
		logic stored_code_error_flag;
		logic correctable_error_flag;
	} npec_status_s;

	typedef enum logic [4:0] {
		NPEC_IDLE = 5'b00001,
		NPEC_ADDR = 5'b00010,
		NPEC_DATA = 5'b00100,
		NPEC_CODE = 5'b01000,
		NPEC_DONE = 5'b10000
	} npec_state_e;

endpackage : npec_pkg

// ==== design/npec_parity.sv ====
// Per-word contribution of one data word to the line and column parity code.
`timescale 1ns/10ps
module npec_parity (
	input  wire logic [15:0]        data,
	input  wire logic               word16,
	input  wire logic [11:0]        index,
	output npec_pkg::npec_code_s    term
);
	import npec_pkg::*;

	logic [7:0]  lo_byte;
	logic [7:0]  hi_byte;
	logic [12:0] lo_idx;
	logic [12:0] hi_idx;
	logic        lo_par;
	logic        hi_par;

	// A 16-bit word is handled as two bytes whose lane is the lowest line index bit.
	assign lo_byte = data[7:0];
	assign hi_byte = word16 ? data[15:8] : 8'h00;
	assign lo_idx  = word16 ? {index, 1'b0} : {1'b0, index};
	assign hi_idx  = {index, 1'b1};
	assign lo_par  = ^lo_byte;
	assign hi_par  = ^hi_byte;

	genvar k;
	generate
		for (k = 0; k < NPEC_LINE_BITS; k++) begin : g_line
			assign term.p_line[k] = (lo_par & lo_idx[k]) ^ (hi_par & hi_idx[k]);
			assign term.n_line[k] = (lo_par & ~lo_idx[k]) ^ (hi_par & ~hi_idx[k]);
		end
		for (k = 0; k < NPEC_COL_BITS; k++) begin : g_col
			assign term.p_col[k] = ^(lo_byte & NPEC_COL_MASK[k])
				^ ^(hi_byte & NPEC_COL_MASK[k]);
			assign term.n_col[k] = ^(lo_byte & ~NPEC_COL_MASK[k])
				^ ^(hi_byte & ~NPEC_COL_MASK[k]);
		end
	endgenerate

endmodule : npec_parity

// ==== test/npec_flash_model.sv ====
// Behavioural flash device that replays one page access on the observed bus.
`timescale 1ns/10ps
module npec_flash_model
	import npec_pkg::*;
(
	input  wire logic          mclk,
	input  wire logic          go,
	input  wire logic [7:0]    cmd,
	input  wire logic [13:0]   nbytes,
	input  wire logic          word16,
	input  wire logic [31:0]   stored,
	input  wire logic [13:0]   flip_a,
	input  wire logic [13:0]   flip_b,
	output npec_pkg::npec_bus_s bus,
	output logic               busy
);

	// Page contents follow a fixed pattern; the two chosen bytes have bit 3 turned over.
	function automatic logic [7:0] byte_at(int b);
		return 8'(b * 37 + 5) ^ ((b == flip_a || b == flip_b) ? 8'h08 : 8'h00);
	endfunction : byte_at

	task automatic put(logic w, logic c, logic a, logic [15:0] d);
		bus <= '{1'b1, w, c, a, d};
		@(posedge mclk);
	endtask : put

	task automatic run();
		int          i;
		logic [31:0] sh;
		busy <= 1'b1;
		put(1'b1, 1'b1, 1'b0, {8'h00, cmd});
		put(1'b1, 1'b0, 1'b1, 16'h0000);
		for (i = 0; i < nbytes; i += word16 ? 2 : 1) begin
			put(cmd != NPEC_CMD_READ, 1'b0, 1'b0,
				word16 ? {byte_at(i + 1), byte_at(i)} : {8'h00, byte_at(i)});
		end
		if (cmd == NPEC_CMD_READ) begin
			for (i = 0; i < 4; i += word16 ? 2 : 1) begin
				sh = stored >> ((i < 2 ? 16 : 0) + (i % 2) * 8);
				put(1'b0, 1'b0, 1'b0, word16 ? sh[15:0] : {8'h00, sh[7:0]});
			end
		end
		// A released bus shows the inverse of its last value, never a stale copy.
		bus <= '{1'b0, 1'b0, 1'b0, 1'b0, ~bus.data};
		busy <= 1'b0;
	endtask : run

	initial begin
		bus = '0;
		busy = 1'b0;
	end

	always @(posedge mclk) begin
		if (go && !busy) begin
			run();
		end
	end

endmodule : npec_flash_model

// ==== test/nand_page_ecc_checker_bench.sv ====
// Self-checking bench for the NAND page code checker with a flash model.
`timescale 1ns/10ps
module nand_page_ecc_checker_bench;
	import npec_pkg::*;

	logic         mclk = 1'b0;
	logic         rst = 1'b1;
	logic         sw_reset = 1'b0;
	logic         ce = 1'b1;
	logic [11:0]  fword;
	logic [3:0]   fbit;
	logic [1:0]   psel = 2'h0;
	logic         word16 = 1'b0;
	logic         go = 1'b0;
	logic [7:0]   cmd = 8'h00;
	logic [13:0]  nbytes = 14'h0200;
	logic [31:0]  stored = 32'h00000000;
	logic [13:0]  flip_a = 14'h3fff;
	logic [13:0]  flip_b = 14'h3fff;
	npec_bus_s    bus;
	logic         busy;
	logic [15:0]  par;
	logic [15:0]  npar;
	npec_status_s stat;
	logic         ready;
	int           miscompares = 0;
	int           checked = 0;

	always #5 mclk = ~mclk;

	npec_checker npec_checker_inst (
		.mclk(mclk), .rst(rst), .ce(ce), .sw_reset(sw_reset),
		.page_length_select(psel), .word16(word16), .bus(bus),
		.parity_result_register(par), .inverse_parity_register(npar),
		.check_status_register(stat), .faulty_word_offset(fword), .faulty_bit_position(fbit),
		.code_ready(ready)
	);

	npec_flash_model npec_flash_model_inst (
		.mclk(mclk), .go(go), .cmd(cmd), .nbytes(nbytes), .word16(word16),
		.stored(stored), .flip_a(flip_a), .flip_b(flip_b), .bus(bus), .busy(busy)
	);

	task automatic check(logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("checks=%0d mismatches=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done

	// Expected code of a clean page of nb bytes, built bit by bit from the line and column sums.
	function automatic npec_code_s code_of(int nb);
		npec_code_s c;
		logic [7:0] v;
		c = '0;
		for (int b = 0; b < nb; b++) begin
			v = 8'(b * 37 + 5);
			for (int k = 0; k < NPEC_LINE_BITS; k++) begin
				if (b[k]) begin
					c.p_line[k] ^= ^v;
				end else begin
					c.n_line[k] ^= ^v;
				end
			end
			for (int j = 0; j < NPEC_COL_BITS; j++) begin
				c.p_col[j] ^= ^(v & NPEC_COL_MASK[j]);
				c.n_col[j] ^= ^(v & ~NPEC_COL_MASK[j]);
			end
		end
		return c;
	endfunction : code_of

	task automatic page(logic [7:0] c, logic [1:0] ps, logic w16);
		int n;
		n = 0;
		psel <= ps;
		word16 <= w16;
		cmd <= c;
		nbytes <= 14'((512 << ps) << w16);
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		@(posedge mclk);
		while (busy === 1'b1 && n < 20000) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 20000) begin
			miscompares++;
		end
		repeat (2) @(posedge mclk);
	endtask : page

	task automatic t_write();
		npec_code_s e;
		for (int ps = 0; ps < 4; ps++) begin
			page(NPEC_CMD_PROGRAM, 2'(ps), ps[0]);
			e = code_of((512 << ps) << ps[0]);
			check(par, {e.p_line, e.p_col});
			check(npar, {e.n_line, e.n_col});
			check(ready, 1'b1);
		end
		$display("test write sizes done");
	endtask : t_write

	// Software stores the clean code XORed with sx in the spare area, then the page is read back.
	task automatic rd(logic [13:0] fa, logic [13:0] fb, logic [31:0] sx, logic w16);
		flip_a <= fa;
		flip_b <= fb;
		stored <= code_of(512 << w16) ^ sx;
		page(NPEC_CMD_READ, 2'h0, w16);
	endtask : rd

	task automatic t_clean();
		for (int w = 0; w < 2; w++) begin
			rd(14'h3fff, 14'h3fff, 32'h00000000, w[0]);
			check(stat, 3'h0);
			check(ready, 1'b1);
		end
		$display("test clean read done");
	endtask : t_clean

	task automatic t_single();
		rd(14'h0064, 14'h3fff, 32'h00000000, 1'b0);
		check(stat, 3'h1);
		check(par, {12'h064, 4'h3});
		check(fword, 12'h064);
		// Software turns the reported bit back over in the byte it has read.
		check(8'(100 * 37 + 5) ^ 8'h08 ^ (8'h01 << fbit), 8'(100 * 37 + 5));
		// An unrelated command with data must leave the results untouched.
		page(8'h30, 2'h0, 1'b0);
		check(stat, 3'h1);
		check(par, {12'h064, 4'h3});
		$display("test single error done");
	endtask : t_single

	task automatic t_code();
		rd(14'h3fff, 14'h3fff, 32'h00010000, 1'b0);
		check(stat, 3'h2);
		// The stored halves XORed against the computed halves leave only the bad bit.
		check(stored[31:16] ^ stored[15:0] ^ par ^ npar, 16'h0001);
		$display("test stored code error done");
	endtask : t_code

	task automatic t_multi();
		rd(14'h0064, 14'h00c8, 32'h00000000, 1'b0);
		check(stat, 3'h4);
		$display("test multiple error done");
	endtask : t_multi

	task automatic t_swreset();
		// With the clock enable low the software reset must not be seen.
		ce <= 1'b0;
		sw_reset <= 1'b1;
		repeat (2) @(posedge mclk);
		check(stat, 3'h4);
		ce <= 1'b1;
		@(posedge mclk);
		sw_reset <= 1'b0;
		repeat (2) @(posedge mclk);
		check(stat, 3'h0);
		check(par, 16'h0000);
		check(npar, 16'h0000);
		check(ready, 1'b0);
		$display("test software reset done");
	endtask : t_swreset

	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_write();
		t_clean();
		t_single();
		t_code();
		t_multi();
		t_swreset();
		test_done();
	end

	initial begin
		#300000;
		miscompares++;
		test_done();
	end

endmodule : nand_page_ecc_checker_bench
